// [design/plc_arb_if.sv]
`timescale 1ns/1ps
interface plc_arb_if;
  import plc_pkg::*;
  plc_vec_t pend;
  plc_vec_t en;
  plc_prio_t prio [1:NUM_SRC];
  plc_id_t best_id;
  plc_prio_t best_prio;
  modport ctrl (output pend, en, prio, input best_id, best_prio);
  modport arb (input pend, en, prio, output best_id, best_prio);
endinterface

// [design/plc_arbiter.sv]
`timescale 1ns/1ps
module plc_arbiter
  import plc_pkg::*;
(
  plc_arb_if.arb arb
);
  // strict compare keeps the lower id on a tie and skips priority zero
  always_comb begin
    arb.best_id = NO_IRQ_ID;
    arb.best_prio = PRIO_NONE;
    for (int i = 1; i <= NUM_SRC; i++) begin
      if (arb.pend[i] && arb.en[i]
          && arb.prio[i] > arb.best_prio) begin
        arb.best_id = plc_id_t'(i);
        arb.best_prio = arb.prio[i];
      end
    end
  end
endmodule

// [design/plc_controller.sv]
`timescale 1ns/1ps
// How it works
// - fifty-one level sources arbitrated over seven nonzero priority levels
// - only aligned 32-bit word accesses; byte enables are ignored
// - a source requests service while its input is held high
// - identifier zero means no interrupt, never a real source
// - ids 1-7 single peripherals, 8-39 pins, 40-51 pulse generators
// - priority word at base plus four times id, bits 2:0 only
// - priority zero never raises a notification
// - priority 1 lowest, 7 highest when choosing the winner
// - equal priorities resolve to the smallest identifier
// - pending bits in two words, bit N mod 32 of word N/32
// - pending bit for id zero always reads zero
// - software clears pending by enabling then claiming the source
// - pending read-only, reset zero; high word bits 31:20 reserved
// - pending array at two words from 0x0C00_1000
// - enable words at 0x0C00_2000 and 0x0C00_2004, read-write
// - threshold word at 0x0C20_0000, read-write
// - priorities have no meaningful reset; software programs them
// - claim read returns best pending enabled id and clears it
// - sources at or below threshold are masked from notification
// - enables packed like pending; enable for id zero reads zero
// - completion write of a non-enabled id is ignored
module plc_controller
  import plc_pkg::*;
(
  input wire logic REF_CLK_IN,
  input wire logic RESET_IN,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [DATA_W-1:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [DATA_W-1:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  input wire logic [NUM_SRC:1] IRQ_SOURCE_IN,
  output logic MACHINE_EXTERNAL_PENDING_OUT
);
  plc_bus_state_t state;
  plc_bus_state_t next_state;
  logic bus_req;
  logic take;
  logic fire_rd;
  logic fire_wr;
  logic aligned;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_rdata;
  plc_vec_t src_meta;
  plc_vec_t src_sync;
  plc_vec_t pend;
  plc_vec_t in_svc;
  plc_vec_t en;
  plc_vec_t set_vec;
  plc_vec_t clr_vec;
  plc_vec_t done_vec;
  plc_prio_t prio [1:NUM_SRC];
  plc_prio_t thresh;
  plc_id_t claim_id;
  logic claim_fire;
  logic irq;

  plc_arb_if arb_bus ();

  plc_arbiter u_arb (
    .arb(arb_bus)
  );

  assign arb_bus.pend = pend;
  assign arb_bus.en = en;
  assign arb_bus.prio = prio;

  // bus slave: one wait state, the answer edge is the only commit edge
  assign bus_req = AVS_READ_IN | AVS_WRITE_IN;
  assign take = bus_req && state == BUS_IDLE;
  assign fire_rd = AVS_READ_IN && state == BUS_ANSWER;
  assign fire_wr = AVS_WRITE_IN && state == BUS_ANSWER;
  assign aligned = AVS_ADDRESS_IN[WORD_SHIFT-1:0] == 2'h0;
  assign AVS_WAITREQUEST_OUT = take;
  assign AVS_READDATA_OUT = rdata;
  assign MACHINE_EXTERNAL_PENDING_OUT = irq;

  always_comb begin
    next_state = state;
    case (state)
      BUS_IDLE: begin
        if (bus_req) begin
          next_state = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        next_state = BUS_IDLE;
      end
      default: begin
        next_state = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      state <= BUS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // read word chosen at the accepting edge and held through the answer
  always_comb begin
    next_rdata = '0;
    if (!aligned) begin
      next_rdata = '0;
    end else if (prio_hit(AVS_ADDRESS_IN)) begin
      next_rdata = DATA_W'(prio[addr_id(AVS_ADDRESS_IN)]);
    end else if (AVS_ADDRESS_IN == PEND_LOW_ADDR) begin
      next_rdata = {pend[LOW_BITS-1:1], 1'h0};
    end else if (AVS_ADDRESS_IN == PEND_HIGH_ADDR) begin
      next_rdata = DATA_W'(pend[NUM_SRC:LOW_BITS]);
    end else if (AVS_ADDRESS_IN == EN_LOW_ADDR) begin
      next_rdata = {en[LOW_BITS-1:1], 1'h0};
    end else if (AVS_ADDRESS_IN == EN_HIGH_ADDR) begin
      next_rdata = DATA_W'(en[NUM_SRC:LOW_BITS]);
    end else if (AVS_ADDRESS_IN == THRESH_ADDR) begin
      next_rdata = DATA_W'(thresh);
    end else if (AVS_ADDRESS_IN == CLAIM_ADDR) begin
      next_rdata = DATA_W'(arb_bus.best_id);
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      rdata <= '0;
    end else if (take && AVS_READ_IN) begin
      rdata <= next_rdata;
    end
  end

  // the id returned is the one cleared, even if a higher one arrives late
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      claim_id <= NO_IRQ_ID;
    end else if (take && AVS_READ_IN && AVS_ADDRESS_IN == CLAIM_ADDR) begin
      claim_id <= arb_bus.best_id;
    end
  end

  assign claim_fire = fire_rd && AVS_ADDRESS_IN == CLAIM_ADDR;
  assign clr_vec = claim_fire ? onehot(DATA_W'(claim_id)) : '0;

  // completion only counts for an id enabled right now
  assign done_vec = (fire_wr && AVS_ADDRESS_IN == CLAIM_ADDR)
    ? (onehot(AVS_WRITEDATA_IN) & en) : '0;

  // sources may come from another clock, so two stages before any use
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      src_meta <= '0;
      src_sync <= '0;
    end else begin
      src_meta <= IRQ_SOURCE_IN;
      src_sync <= src_meta;
    end
  end

  // a held-high line re-pends only after its completion
  assign set_vec = src_sync & ~pend & ~in_svc;

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      pend <= '0;
    end else begin
      pend <= (pend & ~clr_vec) | set_vec;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      in_svc <= '0;
    end else begin
      in_svc <= (in_svc & ~done_vec) | clr_vec;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      en <= '0;
    end else if (fire_wr && AVS_ADDRESS_IN == EN_LOW_ADDR) begin
      en[LOW_BITS-1:1] <= AVS_WRITEDATA_IN[LOW_BITS-1:1];
    end else if (fire_wr && AVS_ADDRESS_IN == EN_HIGH_ADDR) begin
      en[NUM_SRC:LOW_BITS] <= AVS_WRITEDATA_IN[HIGH_BITS-1:0];
    end
  end

  // cleared at reset only so simulation starts clean; software must
  // still program every source it uses
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      for (int i = 1; i <= NUM_SRC; i++) begin
        prio[i] <= PRIO_RESET;
      end
    end else if (fire_wr && prio_hit(AVS_ADDRESS_IN)) begin
      prio[addr_id(AVS_ADDRESS_IN)] <= AVS_WRITEDATA_IN[PRIO_W-1:0];
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      thresh <= THRESH_RESET;
    end else if (fire_wr && AVS_ADDRESS_IN == THRESH_ADDR) begin
      thresh <= AVS_WRITEDATA_IN[PRIO_W-1:0];
    end
  end

  // claim ignores the threshold, the notification does not
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      irq <= 1'h0;
    end else begin
      irq <= arb_bus.best_prio > thresh;
    end
  end

  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (RESET_IN);

  sequence s_req_taken;
    bus_req && state == BUS_IDLE;
  endsequence

  sequence s_answer;
    !AVS_WAITREQUEST_OUT && state == BUS_ANSWER;
  endsequence

  property p_one_wait;
    s_req_taken |-> AVS_WAITREQUEST_OUT ##1 s_answer;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("bus answer not one cycle after request");

  sequence s_claim_read;
    fire_rd && AVS_ADDRESS_IN == CLAIM_ADDR && claim_id != NO_IRQ_ID;
  endsequence

  property p_claim_clears;
    s_claim_read |=> !(|(pend & onehot(DATA_W'($past(claim_id)))));
  endproperty
  a_claim_clears: assert property (p_claim_clears)
    else $error("claimed source still pending");

  property p_claim_returns;
    s_claim_read |-> rdata == DATA_W'(claim_id);
  endproperty
  a_claim_returns: assert property (p_claim_returns)
    else $error("claim data differs from cleared id");

  property p_no_repend;
    (pend & in_svc) == '0;
  endproperty
  a_no_repend: assert property (p_no_repend)
    else $error("source pending while in service");

  property p_level_sets;
    (|set_vec) |=> (pend & $past(set_vec)) == $past(set_vec);
  endproperty
  a_level_sets: assert property (p_level_sets)
    else $error("high source did not become pending");

  property p_notify;
    (arb_bus.best_prio > thresh) |=> irq;
  endproperty
  a_notify: assert property (p_notify)
    else $error("request above threshold not raised");

  property p_mask;
    (arb_bus.best_prio <= thresh) |=> !irq;
  endproperty
  a_mask: assert property (p_mask)
    else $error("request at or below threshold raised");

  property p_zero_prio;
    arb_bus.best_prio == PRIO_NONE |-> arb_bus.best_id == NO_IRQ_ID;
  endproperty
  a_zero_prio: assert property (p_zero_prio)
    else $error("winner chosen with priority zero");

  property p_winner_eligible;
    arb_bus.best_id != NO_IRQ_ID |->
      |(pend & en & onehot(DATA_W'(arb_bus.best_id)));
  endproperty
  a_winner_eligible: assert property (p_winner_eligible)
    else $error("winner not pending and enabled");

  property p_pend_low_read;
    fire_rd && AVS_ADDRESS_IN == PEND_LOW_ADDR |-> rdata[0] == 1'h0;
  endproperty
  a_pend_low_read: assert property (p_pend_low_read)
    else $error("pending bit zero read as one");

  property p_pend_high_read;
    fire_rd && AVS_ADDRESS_IN == PEND_HIGH_ADDR
      |-> rdata[DATA_W-1:HIGH_BITS] == '0;
  endproperty
  a_pend_high_read: assert property (p_pend_high_read)
    else $error("reserved pending bits read nonzero");

  property p_prio_read;
    fire_rd && prio_hit(AVS_ADDRESS_IN) |-> rdata[DATA_W-1:PRIO_W] == '0;
  endproperty
  a_prio_read: assert property (p_prio_read)
    else $error("priority upper bits read nonzero");

  property p_done_ignored;
    fire_wr && AVS_ADDRESS_IN == CLAIM_ADDR && done_vec == '0
      |=> in_svc == $past(in_svc);
  endproperty
  a_done_ignored: assert property (p_done_ignored)
    else $error("ignored completion changed service state");

  property p_done_releases;
    (|done_vec) |=> (in_svc & $past(done_vec)) == '0;
  endproperty
  a_done_releases: assert property (p_done_releases)
    else $error("completion did not release source");

  property p_thresh_write;
    fire_wr && aligned && AVS_ADDRESS_IN == THRESH_ADDR
      |=> thresh == $past(AVS_WRITEDATA_IN[PRIO_W-1:0]);
  endproperty
  a_thresh_write: assert property (p_thresh_write)
    else $error("threshold write not stored");

  property p_en_zero;
    fire_rd && AVS_ADDRESS_IN == EN_LOW_ADDR |-> rdata[0] == 1'h0;
  endproperty
  a_en_zero: assert property (p_en_zero)
    else $error("enable bit zero read as one");

  property p_en_high_read;
    fire_rd && AVS_ADDRESS_IN == EN_HIGH_ADDR
      |-> rdata[DATA_W-1:HIGH_BITS] == '0;
  endproperty
  a_en_high_read: assert property (p_en_high_read)
    else $error("reserved enable bits read nonzero");
endmodule

// [design/plc_pkg.sv]
package plc_pkg;
  localparam int NUM_SRC = 51;
  localparam int PRIO_W = 3;
  localparam int ID_W = 6;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 32;
  localparam int LOW_BITS = 32;
  localparam int HIGH_BITS = 20;
  localparam int WORD_SHIFT = 2;
  localparam int PRIO_MAX = 7;

  localparam logic [ADDR_W-1:0] PRIO_BASE = 32'h0C00_0000;
  localparam logic [ADDR_W-1:0] PRIO_FIRST_ADDR = 32'h0C00_0004;
  localparam logic [ADDR_W-1:0] PRIO_LAST_ADDR = 32'h0C00_00CC;
  localparam logic [ADDR_W-1:0] PEND_LOW_ADDR = 32'h0C00_1000;
  localparam logic [ADDR_W-1:0] PEND_HIGH_ADDR = 32'h0C00_1004;
  localparam logic [ADDR_W-1:0] EN_LOW_ADDR = 32'h0C00_2000;
  localparam logic [ADDR_W-1:0] EN_HIGH_ADDR = 32'h0C00_2004;
  localparam logic [ADDR_W-1:0] THRESH_ADDR = 32'h0C20_0000;
  localparam logic [ADDR_W-1:0] CLAIM_ADDR = 32'h0C20_0004;

  localparam logic [PRIO_W-1:0] PRIO_NONE = 3'h0;
  localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h0;
  localparam logic [PRIO_W-1:0] THRESH_RESET = 3'h0;
  localparam logic [ID_W-1:0] NO_IRQ_ID = 6'h00;

  typedef logic [PRIO_W-1:0] plc_prio_t;
  typedef logic [ID_W-1:0] plc_id_t;
  typedef logic [NUM_SRC:1] plc_vec_t;
  typedef enum logic {BUS_IDLE, BUS_ANSWER} plc_bus_state_t;

  // aligned word inside the priority block, sources 1..51 only
  function automatic logic prio_hit(input logic [ADDR_W-1:0] a);
    return a >= PRIO_FIRST_ADDR && a <= PRIO_LAST_ADDR
      && a[WORD_SHIFT-1:0] == 2'h0;
  endfunction

  function automatic plc_id_t addr_id(input logic [ADDR_W-1:0] a);
    return a[WORD_SHIFT +: ID_W];
  endfunction

  // one bit per real source; zero and out-of-range ids give no bit
  function automatic plc_vec_t onehot(input logic [DATA_W-1:0] v);
    plc_vec_t r;
    r = '0;
    for (int i = 1; i <= NUM_SRC; i++) begin
      if (v == DATA_W'(i)) begin
        r[i] = 1'h1;
      end
    end
    return r;
  endfunction
endpackage

// [verif/plc_controller_bench.sv]
`timescale 1ns/1ps
module plc_controller_bench;
  import plc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic wait_req;
  logic irq;
  logic [NUM_SRC:1] raise = '0;
  logic [NUM_SRC:1] drop = '0;
  logic [NUM_SRC:1] lines;
  int n_errors = 0;
  int num_checks = 0;
  int prio [NUM_SRC+1];
  bit en [NUM_SRC+1];
  bit pend [NUM_SRC+1];
  bit busy [NUM_SRC+1];
  int thr;
  int id;
  int got [$];
  logic [31:0] v;
  logic [31:0] zero_tab [8] = '{PEND_LOW_ADDR, PEND_HIGH_ADDR, EN_LOW_ADDR,
    EN_HIGH_ADDR, THRESH_ADDR, CLAIM_ADDR, PRIO_BASE, 32'h0C00_1008};

  always #12.5 clk = ~clk;

  plc_src_model i_src (.clk_in(clk), .rst_in(rst), .raise_in(raise),
    .drop_in(drop), .line_out(lines));

  plc_controller i_dut (.REF_CLK_IN(clk), .RESET_IN(rst),
    .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
    .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(4'hF),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_req),
    .IRQ_SOURCE_IN(lines), .MACHINE_EXTERNAL_PENDING_OUT(irq));

  task automatic close_out();
    if (n_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // request held until the edge where waitrequest is seen low
  task automatic bus(input bit w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (wait_req === 1'b0) break;
    end
    if (i == 20) begin
      n_errors++;
      close_out();
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wr32(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string what, input logic [31:0] a,
                        input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, '0, q);
    chk(what, q, exp);
  endtask

  function automatic logic [31:0] pend_word(input int k);
    logic [31:0] r;
    r = '0;
    for (int n = 1; n <= NUM_SRC; n++) begin
      if (n / 32 == k) r[n % 32] = pend[n];
    end
    return r;
  endfunction

  // descending scan with >= lets the smallest id win a tie
  function automatic int best();
    int b;
    b = 0;
    for (int n = NUM_SRC; n >= 1; n--) begin
      if (pend[n] && en[n] && prio[n] > 0 && prio[n] >= prio[b]) b = n;
    end
    return b;
  endfunction

  task automatic chk_state();
    repeat (6) @(posedge clk);
    for (int n = 1; n <= NUM_SRC; n++) begin
      if (lines[n] && !busy[n]) pend[n] = 1'b1;
    end
    rd_chk("pending low", PEND_LOW_ADDR, pend_word(0));
    rd_chk("pending high", PEND_HIGH_ADDR, pend_word(1));
    chk("irq", {31'h0, irq}, {31'h0, prio[best()] > thr});
  endtask

  initial begin
    void'($urandom(41));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wr32(PEND_LOW_ADDR, '1);
    foreach (zero_tab[i]) begin
      rd_chk("reset value", zero_tab[i], '0);
    end
    for (int n = 1; n <= NUM_SRC; n++) begin
      v = $urandom;
      prio[n] = v[2:0];
      wr32(PRIO_BASE + 32'(4 * n), v);
      rd_chk("priority", PRIO_BASE + 32'(4 * n), {29'h0, v[2:0]});
      en[n] = 1'b1;
    end
    wr32(EN_LOW_ADDR, '1);
    wr32(EN_HIGH_ADDR, '1);
    rd_chk("enable low", EN_LOW_ADDR, 32'hFFFF_FFFE);
    rd_chk("enable high", EN_HIGH_ADDR, 32'h000F_FFFF);
    repeat (4) begin
      @(posedge clk);
      raise <= NUM_SRC'({$urandom, $urandom});
      @(posedge clk);
      raise <= '0;
      v = $urandom;
      thr = v[2:0];
      wr32(THRESH_ADDR, v);
      // a misaligned write must leave the word alone
      wr32(THRESH_ADDR + 32'h1, ~v);
      rd_chk("threshold", THRESH_ADDR, {29'h0, v[2:0]});
      rd_chk("misaligned", THRESH_ADDR + 32'h2, '0);
      chk_state();
      do begin
        id = best();
        rd_chk("claim id", CLAIM_ADDR, id);
        if (id != 0) begin
          pend[id] = 1'b0;
          busy[id] = 1'b1;
          got.push_back(id);
        end
        chk_state();
      end while (id != 0);
      // low-word completions arrive while disabled and must be dropped
      wr32(EN_LOW_ADDR, '0);
      for (int n = 1; n < 32; n++) en[n] = 1'b0;
      foreach (got[i]) begin
        wr32(CLAIM_ADDR, got[i]);
        if (en[got[i]]) busy[got[i]] = 1'b0;
      end
      chk_state();
      wr32(EN_LOW_ADDR, '1);
      for (int n = 1; n < 32; n++) en[n] = 1'b1;
      @(posedge clk);
      drop <= NUM_SRC'({$urandom, $urandom});
      @(posedge clk);
      drop <= '0;
      repeat (4) @(posedge clk);
      foreach (got[i]) begin
        wr32(CLAIM_ADDR, got[i]);
        busy[got[i]] = 1'b0;
      end
      got.delete();
      chk_state();
    end
    close_out();
  end
endmodule

// [verif/plc_src_model.sv]
`timescale 1ns/1ps
module plc_src_model
  import plc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [NUM_SRC:1] raise_in,
  input wire logic [NUM_SRC:1] drop_in,
  output logic [NUM_SRC:1] line_out
);
  // a line stays high until its handler drops it, as a level source does
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      line_out <= '0;
    end else begin
      line_out <= (line_out | raise_in) & ~drop_in;
    end
  end
endmodule
